// ==== shared/cardbus_diag_cfg.svh ====
// constants for the device control and diagnostic register bank
`ifndef CARDBUS_DIAG_CFG_SVH
`define CARDBUS_DIAG_CFG_SVH

// register indices; byte address is four times the index
`define DEV_CTRL_IDX 8'h92
`define DIAG_CTRL_IDX 8'h93
// address bit that selects function 1
`define FN_SEL_BIT 10
`define FN_ADDR_W 12

`define DEV_CTRL_RST 8'h66
`define DIAG_CTRL_RST 8'h60

// shared copy bits and per-function bits
`define DEV_GLOBAL_MASK 8'h4F
`define DEV_LOCAL_MASK 8'hA0
`define DIAG_GLOBAL_MASK 8'h9E
`define DIAG_LOCAL_MASK 8'h21
`define DIAG_FIXED_ONE 8'h40

// field positions
`define DEV_HOLD_BIT 7
`define DEV_LV_BIT 6
`define DEV_RSVD_BIT 4
`define DEV_MODE_LSB 1
`define DIAG_MASK_BIT 7
`define DIAG_ROUTE_BIT 5
`define DIAG_DTX_BIT 4
`define DIAG_RETRY_BIT 3
`define DIAG_CB_BIT 2
`define DIAG_HB_BIT 1
`define DIAG_ZV_BIT 0

// timing counts in clocks
`define RETRY_LAT_SHORT 7'h10
`define RETRY_LAT_LONG 7'h40
`define DISCARD_SHORT 16'h0400
`define DISCARD_LONG 16'h8000

`endif

// ==== shared/cardbus_diag_pkg.sv ====
// types for the device control and diagnostic register bank
`default_nettype none
package cardbus_diag_pkg;

	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_t;

	typedef enum logic [1:0] {
		MODE_PARALLEL = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_SER_PAR = 2'b10,
		MODE_SERIAL = 2'b11
	} irq_mode_t;

endpackage
`default_nettype wire

// ==== logic/cardbus_diag_regs.sv ====
// device control and diagnostic register bank with apb access
// Behaviour
// [RQ1] socket power hold refuses removal in D3
// [RQ2] bit 6 forces reported 3-V capability
// [RQ3] bit 5 diagnostic bit resets to 1
// [RQ4] device control bit 4 reads 0
// [RQ5] software writes only 0 to bit 3
// [RQ6] two-bit field selects interrupt signalling mode
// [RQ7] software writes only 0 to bit 0
// [RQ8] only global reset restores these bits
// [RQ9] shared bits accessed only via function 0; function 1 writes are ignored but its reads return them
// [RQ10] software writes only zeros to diagnostic
// [RQ11] id mask bit makes id reads ones
// [RQ12] diagnostic bit 6 always reads 1
// [RQ13] routing bit picks card status change source
// [RQ14] diagnostic bit 4 disables delayed transactions
// [RQ15] diagnostic bit 3 extends retry latency
// [RQ16] bit 2 picks card side discard length
// [RQ17] bit 1 picks host side discard length
// [RQ18] bit 0 selects zoomed video model
// [RQ19] shared bits kept in one storage element
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cardbus_diag_cfg.svh"

module cardbus_diag_regs
	import cardbus_diag_pkg::*;
(
	input wire logic core_clk_i, // 40 MHz clock
	input wire logic arst_n_i, // global reset, active low
	input wire apb_req_t apb_req_i, // apb request
	output apb_rsp_t apb_rsp_o, // apb answer
	input wire logic [1:0] sock_off_req_i, // power removal request
	input wire logic [1:0] fn_d3_i, // function in D3
	output logic [1:0] sock_off_ack_o, // removal granted
	input wire logic [31:0] id_true_i, // true vendor/device id
	output logic [63:0] id_read_o, // id as read per function
	input wire logic [1:0] exca_b4_i, // status change enable
	input wire logic [7:0] exca_irq_sel_i, // irq select nibbles
	output logic [1:0] status_change_pci_o, // status change to pci
	output logic [1:0] zv_new_model_o, // new zoomed video model
	output logic low_voltage_ok_o, // socket 3-V capable
	output logic irq_par_pci_o, // parallel pci interrupts
	output logic irq_par_intab_o, // parallel inta and intb
	output logic irq_serial_o, // serialized irq
	output logic irq_ser_pci_o, // serialized pci interrupts
	output logic delayed_txn_off_o, // delayed transactions off
	output logic [6:0] retry_latency_o, // retry latency clocks
	output logic [15:0] card_bus_discard_len_o, // card side timer
	output logic [15:0] host_bus_discard_len_o // host side timer
);

	////////////////////////////////////////////////////////////////
	// storage

	logic [7:0] glob_dev_r;
	logic [7:0] glob_diag_r;
	logic [7:0] fn_dev_r [2];
	logic [7:0] fn_diag_r [2];
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	////////////////////////////////////////////////////////////////
	// address decode

	localparam logic [9:0] DEV_ADDR = {`DEV_CTRL_IDX, 2'b00};
	localparam logic [9:0] DIAG_ADDR = {`DIAG_CTRL_IDX, 2'b00};

	logic fn_sel;
	logic dev_hit;
	logic diag_hit;
	logic access;
	logic wr_done;
	logic wr_lane;

	assign fn_sel = apb_req_i.paddr[`FN_SEL_BIT];
	assign dev_hit = apb_req_i.paddr[11] == 1'b0 &&
		apb_req_i.paddr[9:0] == DEV_ADDR;
	assign diag_hit = apb_req_i.paddr[11] == 1'b0 &&
		apb_req_i.paddr[9:0] == DIAG_ADDR;
	assign access = apb_req_i.psel && apb_req_i.penable;
	assign wr_done = access && pready_r && apb_req_i.pwrite;
	assign wr_lane = apb_req_i.pstrb[0];

	////////////////////////////////////////////////////////////////
	// shared bits: written only through function 0

	logic [7:0] wbyte;
	assign wbyte = apb_req_i.pwdata[7:0];

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			glob_dev_r <= `DEV_CTRL_RST & `DEV_GLOBAL_MASK; // RQ8
			glob_diag_r <= `DIAG_CTRL_RST & `DIAG_GLOBAL_MASK; // RQ8
		end
		else if (wr_done && wr_lane && !fn_sel) // RQ9 RQ19
		begin
			if (dev_hit)
				glob_dev_r <= wbyte & `DEV_GLOBAL_MASK; // RQ4
			if (diag_hit)
				glob_diag_r <= wbyte & `DIAG_GLOBAL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////
	// per-function bits and per-function outputs

	logic [7:0] rd_dev [2];
	logic [7:0] rd_diag [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_fn
			logic mine;
			logic [3:0] nib;
			assign mine = fn_sel == 1'(g);
			assign nib = exca_irq_sel_i[4*g +: 4];

			always_ff @(posedge core_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					fn_dev_r[g] <= `DEV_CTRL_RST & `DEV_LOCAL_MASK; // RQ3 RQ8
					fn_diag_r[g] <= `DIAG_CTRL_RST & `DIAG_LOCAL_MASK; // RQ8
				end
				else if (wr_done && wr_lane && mine)
				begin
					if (dev_hit)
						fn_dev_r[g] <= wbyte & `DEV_LOCAL_MASK;
					if (diag_hit)
						fn_diag_r[g] <= wbyte & `DIAG_LOCAL_MASK;
				end
			end

			assign rd_dev[g] = glob_dev_r | fn_dev_r[g]; // RQ19
			assign rd_diag[g] = glob_diag_r | fn_diag_r[g] |
				`DIAG_FIXED_ONE; // RQ12

			// removal refused while held and in D3
			assign sock_off_ack_o[g] = sock_off_req_i[g] &&
				!(fn_dev_r[g][`DEV_HOLD_BIT] && fn_d3_i[g]); // RQ1

			always_ff @(posedge core_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					id_read_o[32*g +: 32] <= 32'h0000_0000;
					status_change_pci_o[g] <= 1'b0;
					zv_new_model_o[g] <= 1'b0;
				end
				else
				begin
					id_read_o[32*g +: 32] <= glob_diag_r[`DIAG_MASK_BIT] ?
						32'hFFFF_FFFF : id_true_i; // RQ11
					status_change_pci_o[g] <= fn_diag_r[g][`DIAG_ROUTE_BIT] ?
						(nib == 4'h0) : exca_b4_i[g]; // RQ13
					zv_new_model_o[g] <= !fn_diag_r[g][`DIAG_ZV_BIT]; // RQ18
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// shared outputs

	irq_mode_t irq_mode;
	assign irq_mode = irq_mode_t'(glob_dev_r[`DEV_MODE_LSB +: 2]);

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			low_voltage_ok_o <= 1'b0;
			irq_par_pci_o <= 1'b0;
			irq_par_intab_o <= 1'b0;
			irq_serial_o <= 1'b0;
			irq_ser_pci_o <= 1'b0;
		end
		else
		begin
			low_voltage_ok_o <= glob_dev_r[`DEV_LV_BIT]; // RQ2
			irq_par_pci_o <= 1'b0;
			irq_par_intab_o <= 1'b0;
			irq_serial_o <= 1'b0;
			irq_ser_pci_o <= 1'b0;
			case (irq_mode) // RQ6
				MODE_SER_PAR:
				begin
					irq_serial_o <= 1'b1;
					irq_par_intab_o <= 1'b1;
				end
				MODE_SERIAL:
				begin
					irq_serial_o <= 1'b1;
					irq_ser_pci_o <= 1'b1;
				end
				default:
					irq_par_pci_o <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			delayed_txn_off_o <= 1'b0;
			retry_latency_o <= `RETRY_LAT_SHORT;
			card_bus_discard_len_o <= `DISCARD_LONG;
			host_bus_discard_len_o <= `DISCARD_LONG;
		end
		else
		begin
			delayed_txn_off_o <= glob_diag_r[`DIAG_DTX_BIT]; // RQ14
			retry_latency_o <= glob_diag_r[`DIAG_RETRY_BIT] ?
				`RETRY_LAT_LONG : `RETRY_LAT_SHORT; // RQ15
			card_bus_discard_len_o <= glob_diag_r[`DIAG_CB_BIT] ?
				`DISCARD_SHORT : `DISCARD_LONG; // RQ16
			host_bus_discard_len_o <= glob_diag_r[`DIAG_HB_BIT] ?
				`DISCARD_SHORT : `DISCARD_LONG; // RQ17
		end
	end

	////////////////////////////////////////////////////////////////
	// apb answer: one wait state, registered read data

	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		if (dev_hit)
			rd_byte = rd_dev[fn_sel];
		else if (diag_hit)
			rd_byte = rd_diag[fn_sel];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (access && !pready_r)
		begin
			pready_r <= 1'b1;
			prdata_r <= {24'h00_0000, rd_byte};
			pslverr_r <= !(dev_hit || diag_hit);
		end
		else
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	assign apb_rsp_o.pready = pready_r;
	assign apb_rsp_o.prdata = prdata_r;
	assign apb_rsp_o.pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////
	// checks

	logic rd_first;
	assign rd_first = access && !pready_r && !apb_req_i.pwrite;

	property p_rsvd_zero;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		rd_first && dev_hit |=> apb_rsp_o.pready && !apb_rsp_o.prdata[4];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // RQ4
		else $error("device control bit 4 read nonzero");
	property p_fixed_one;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		rd_first && diag_hit |=> apb_rsp_o.prdata[6];
	endproperty
	a_fixed_one: assert property (p_fixed_one) // RQ12
		else $error("diagnostic bit 6 read zero");
	property p_fn1_no_global;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		wr_done && fn_sel |=> $stable(glob_dev_r) && $stable(glob_diag_r);
	endproperty
	a_fn1_no_global: assert property (p_fn1_no_global) // RQ9
		else $error("function 1 write changed shared bits");
	property p_shared_read;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		rd_first && dev_hit |=> (apb_rsp_o.prdata[6] == glob_dev_r[`DEV_LV_BIT]);
	endproperty
	a_shared_read: assert property (p_shared_read) // RQ19
		else $error("shared bit read differs from single copy");
	property p_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		fn_dev_r[0][`DEV_HOLD_BIT] && fn_d3_i[0] |-> !sock_off_ack_o[0];
	endproperty
	a_hold: assert property (p_hold) // RQ1
		else $error("socket power removed while held in D3");
	property p_lv_force;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		wr_done && wr_lane && !fn_sel && dev_hit |=> ##1
		low_voltage_ok_o == $past(wbyte[`DEV_LV_BIT], 2);
	endproperty
	a_lv_force: assert property (p_lv_force) // RQ2
		else $error("3-V capability does not follow write");
	property p_mode_serial;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		irq_mode == MODE_SERIAL && $stable(irq_mode) |=>
		irq_serial_o && irq_ser_pci_o && !irq_par_pci_o && !irq_par_intab_o;
	endproperty
	a_mode_serial: assert property (p_mode_serial) // RQ6
		else $error("serial interrupt mode not decoded");
	property p_mode_par;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		irq_mode == MODE_PARALLEL |=> irq_par_pci_o && !irq_serial_o;
	endproperty
	a_mode_par: assert property (p_mode_par) // RQ6
		else $error("parallel interrupt mode not decoded");
	property p_id_mask;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		glob_diag_r[`DIAG_MASK_BIT] |=> id_read_o == 64'hFFFF_FFFF_FFFF_FFFF;
	endproperty
	a_id_mask: assert property (p_id_mask) // RQ11
		else $error("id not masked to all ones");
	property p_retry;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		glob_diag_r[`DIAG_RETRY_BIT] |=> retry_latency_o == 7'h40;
	endproperty
	a_retry: assert property (p_retry) // RQ15
		else $error("retry latency not extended to 64");
	property p_discard;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		!glob_diag_r[`DIAG_CB_BIT] && glob_diag_r[`DIAG_HB_BIT] |=>
		card_bus_discard_len_o == 16'h8000 && host_bus_discard_len_o == 16'h0400;
	endproperty
	a_discard: assert property (p_discard) // RQ16 RQ17
		else $error("discard timer length wrong");
	property p_status_route;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		!fn_diag_r[0][`DIAG_ROUTE_BIT] |=>
		status_change_pci_o[0] == $past(exca_b4_i[0]);
	endproperty
	a_status_route: assert property (p_status_route) // RQ13
		else $error("status change routing wrong");
	property p_zv;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		fn_diag_r[1][`DIAG_ZV_BIT] |=> !zv_new_model_o[1];
	endproperty
	a_zv: assert property (p_zv) // RQ18
		else $error("zoomed video model select wrong");
	property p_dtx;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		$rose(glob_diag_r[`DIAG_DTX_BIT]) |=> delayed_txn_off_o;
	endproperty
	a_dtx: assert property (p_dtx) // RQ14
		else $error("delayed transactions not disabled");

	c_wr_fn0: cover property (@(posedge core_clk_i) wr_done && !fn_sel && dev_hit);
	c_wr_fn1: cover property (@(posedge core_clk_i) wr_done && fn_sel && diag_hit);
	c_unmapped: cover property (@(posedge core_clk_i) pready_r && pslverr_r);
	c_refuse: cover property (@(posedge core_clk_i) sock_off_req_i[0] && !sock_off_ack_o[0]);

endmodule // cardbus_diag_regs
`default_nettype wire

// ==== tb/cardbus_host_model.sv ====
// host software model issuing apb configuration accesses
`timescale 1ns/1ps
`default_nettype none

module cardbus_host_model
	import cardbus_diag_pkg::*;
(
	input wire logic core_clk_i, // bank clock
	input wire apb_rsp_t apb_rsp_i, // answer from the bank
	output var apb_req_t apb_req_o, // request to the bank
	output logic hung_o // last transfer got no answer
);
	// byte lanes of the next write; the bench lowers lane 0 to test a masked write
	logic [3:0] strb_sel;

	initial
	begin
		apb_req_o = '0;
		hung_o = 1'b0;
		strb_sel = 4'hF;
	end

	////////////////////////////////////////
	// one setup cycle, then access until pready is sampled high
	task automatic xfer(input logic wr, input logic [11:0] adr, input logic [7:0] dat,
		output logic [7:0] rd, output logic err);
		int n;
		begin
			@(posedge core_clk_i);
			apb_req_o.paddr <= adr;
			apb_req_o.psel <= 1'b1;
			apb_req_o.penable <= 1'b0;
			apb_req_o.pwrite <= wr;
			apb_req_o.pwdata <= {24'h0000_00, dat};
			apb_req_o.pstrb <= strb_sel;
			@(posedge core_clk_i);
			apb_req_o.penable <= 1'b1;
			n = 0;
			do
			begin
				@(posedge core_clk_i);
				n++;
			end
			while (apb_rsp_i.pready !== 1'b1 && n < 20);
			rd = apb_rsp_i.prdata[7:0];
			err = apb_rsp_i.pslverr;
			hung_o = (n >= 20);
			// released lines no longer show the old value
			apb_req_o.psel <= 1'b0;
			apb_req_o.penable <= 1'b0;
			apb_req_o.paddr <= ~adr;
			apb_req_o.pwdata <= ~{24'h0000_00, dat};
		end
	endtask
endmodule // cardbus_host_model

`default_nettype wire

// ==== tb/tb_cardbus_diag_regs.sv ====
// self-checking bench for the device control and diagnostic bank
`timescale 1ns/1ps
`default_nettype none
`include "cardbus_diag_cfg.svh"

module tb_cardbus_diag_regs
	import cardbus_diag_pkg::*;
;
	logic clk, arst_n, hung, lv, p_pci, p_ab, ser, s_pci, dtx;
	apb_req_t req;
	apb_rsp_t rsp;
	logic [1:0] off_req, d3, ack, b4, chg, zv;
	logic [31:0] id_true, r;
	logic [63:0] id_rd;
	logic [7:0] sel, dev_g, diag_g;
	logic [7:0] dev_l [2];
	logic [7:0] diag_l [2];
	logic [6:0] rl;
	logic [15:0] cbl, hbl;
	int fail_count, checks_done, seed;

	cardbus_diag_regs cardbus_diag_regs_inst (.core_clk_i(clk), .arst_n_i(arst_n),
		.apb_req_i(req), .apb_rsp_o(rsp), .sock_off_req_i(off_req), .fn_d3_i(d3),
		.sock_off_ack_o(ack), .id_true_i(id_true), .id_read_o(id_rd), .exca_b4_i(b4),
		.exca_irq_sel_i(sel), .status_change_pci_o(chg), .zv_new_model_o(zv),
		.low_voltage_ok_o(lv),
		.irq_par_pci_o(p_pci), .irq_par_intab_o(p_ab), .irq_serial_o(ser),
		.irq_ser_pci_o(s_pci), .delayed_txn_off_o(dtx), .retry_latency_o(rl),
		.card_bus_discard_len_o(cbl), .host_bus_discard_len_o(hbl));
	cardbus_host_model cardbus_host_model_inst (.core_clk_i(clk), .apb_rsp_i(rsp),
		.apb_req_o(req), .hung_o(hung));

	always #12.5 clk = ~clk;

	////////////////////////////////////////
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic e);
		cardbus_host_model_inst.xfer(w, a, d, q, e);
		if (hung)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask

	function automatic logic [11:0] adr(input logic f, input logic [7:0] idx);
		return {1'b0, f, idx, 2'b00};
	endfunction

	task automatic reset_model;
		dev_g = `DEV_CTRL_RST;
		dev_l = '{`DEV_CTRL_RST, `DEV_CTRL_RST};
		diag_g = `DIAG_CTRL_RST;
		diag_l = '{`DIAG_CTRL_RST, `DIAG_CTRL_RST};
	endtask

	task automatic check_regs;
		logic [7:0] q;
		logic e;
		for (int f = 0; f < 2; f++)
		begin
			acc(1'b0, adr(f[0], `DEV_CTRL_IDX), 8'h00, q, e);
			chk("dev_ctrl", q, (dev_g & 8'h4F) | (dev_l[f] & 8'hA0));
			acc(1'b0, adr(f[0], `DIAG_CTRL_IDX), 8'h00, q, e);
			chk("diag_ctrl", q, (diag_g & 8'h9E) | (diag_l[f] & 8'h21) | 8'h40);
		end
	endtask

	task automatic check_side;
		logic [3:0] m;
		repeat (3) @(posedge clk);
		#1;
		case (dev_g[2:1])
			2'b10: m = 4'b0110;
			2'b11: m = 4'b0011;
			default: m = 4'b1000;
		endcase
		chk("low_v", lv, dev_g[6]);
		chk("irq_mode", {p_pci, p_ab, ser, s_pci}, m);
		chk("dtx_off", dtx, diag_g[4]);
		chk("retry", rl, diag_g[3] ? 7'h40 : 7'h10);
		chk("cb_len", cbl, diag_g[2] ? 16'h0400 : 16'h8000);
		chk("hb_len", hbl, diag_g[1] ? 16'h0400 : 16'h8000);
		chk("id_read", id_rd, diag_g[7] ? 64'hFFFF_FFFF_FFFF_FFFF : {id_true, id_true});
		for (int f = 0; f < 2; f++)
		begin
			chk("zv", zv[f], !diag_l[f][0]);
			chk("status_chg", chg[f], diag_l[f][5] ? (sel[f*4+:4] == 4'h0) : b4[f]);
			chk("sock_ack", ack[f], off_req[f] & ~(dev_l[f][7] & d3[f]));
		end
	endtask

	////////////////////////////////////////
	initial
	begin
		logic [7:0] q, d;
		logic e;
		seed = 2;
		fail_count = 0;
		checks_done = 0;
		clk = 0;
		arst_n = 0;
		{off_req, d3, b4, sel} = '0;
		id_true = 32'h1357_9BDF;
		reset_model();
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		check_regs();
		check_side();
		$display("test reset values done");
		for (int i = 0; i < 24; i++)
		begin
			r = $random(seed);
			@(posedge clk);
			{d3, off_req, b4} <= r[5:0];
			sel <= r[14] ? r[13:6] : 8'h00;
			id_true <= $random(seed);
			d = r[23:16] & 8'hF6;
			d[2:1] = i[1:0];
			acc(1'b1, adr(i[2], `DEV_CTRL_IDX), d, q, e);
			chk("wr_err", e, 1'b0);
			if (!i[2])
				dev_g = d;
			dev_l[i[2]] = d;
			d = r[31:24] ^ i[7:0]; // ones written on purpose to reach every control
			acc(1'b1, adr(i[2] ^ i[3], `DIAG_CTRL_IDX), d, q, e);
			if (!(i[2] ^ i[3]))
				diag_g = d;
			diag_l[i[2] ^ i[3]] = d;
			check_regs();
			check_side();
		end
		$display("test random writes done");
		// software leaves the diagnostic register at zero through both functions
		for (int f = 0; f < 2; f++)
		begin
			acc(1'b1, adr(f[0], `DIAG_CTRL_IDX), 8'h00, q, e);
			if (f == 0)
				diag_g = 8'h00;
			diag_l[f] = 8'h00;
		end
		check_regs();
		check_side();
		$display("test zero diagnostic done");
		acc(1'b1, 12'hA48, 8'hFF, q, e);
		chk("unmapped_wr_err", e, 1'b1);
		acc(1'b0, 12'hA4C, 8'h00, q, e);
		chk("unmapped_rd_err", e, 1'b1);
		chk("unmapped_rd_data", q, 8'h00);
		check_regs();
		$display("test unmapped done");
		// a write without byte lane 0 leaves both registers as they are
		cardbus_host_model_inst.strb_sel = 4'hE;
		acc(1'b1, adr(1'b0, `DEV_CTRL_IDX), 8'hB6, q, e);
		cardbus_host_model_inst.strb_sel = 4'hF;
		chk("strb_err", e, 1'b0);
		check_regs();
		$display("test lane strobe done");
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		reset_model();
		check_regs();
		check_side();
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule // tb_cardbus_diag_regs

`default_nettype wire
